/* File: logic/tws_defines.svh */
// constants for the two-wire port: timing, address and buffer figures
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
`define TWS_CORE_CLK_NS  5
`define TWS_SCL_HALF_NS  1250
`define TWS_SCL_HALF_CYC ((`TWS_SCL_HALF_NS + `TWS_CORE_CLK_NS - 1) / `TWS_CORE_CLK_NS)
`define TWS_TIMER_LAST   8'hf9
`define TWS_DEV_BASE     7'h60
`define TWS_BYTE_BITS    4'h8
`define TWS_FIFO_WIDTH   16
`define TWS_FIFO_DEPTH   4
`endif

/* File: logic/tws_pkg.sv */
// types shared by both ends of the two-wire link
package tws_pkg;
   typedef enum logic [7:0] {
      S_IDLE     = 8'h01,
      S_ADDR     = 8'h02,
      S_ADDR_ACK = 8'h04,
      S_WDATA    = 8'h08,
      S_WACK     = 8'h10,
      S_RDATA    = 8'h20,
      S_RACK     = 8'h40,
      S_IGNORE   = 8'h80
   } slave_state_t;

   typedef enum logic [4:0] {
      M_IDLE   = 5'h01,
      M_START  = 5'h02,
      M_STOP   = 5'h04,
      M_BIT_LO = 5'h08,
      M_BIT_HI = 5'h10
   } master_state_t;

   typedef enum logic [3:0] {
      OP_START = 4'h1,
      OP_STOP  = 4'h2,
      OP_WRITE = 4'h4,
      OP_READ  = 4'h8
   } master_op_t;
endpackage

/* File: logic/tws_link_if.sv */
// open-drain two-wire link joining the bus master and the tuner port
`timescale 1ns/10ps
interface tws_link_if;
   logic m_scl_out;
   logic m_scl_oe;
   logic m_sda_out;
   logic m_sda_oe;
   logic s_sda_out;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // wired-and with pull-ups: any enabled low driver wins
   assign scl = ~(m_scl_oe & ~m_scl_out);
   assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

   modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
   modport slave  (output s_sda_out, s_sda_oe, input scl, sda);
endinterface

/* File: logic/tws_fifo.sv */
// small valid/ready fifo for received register writes
`timescale 1ns/10ps
module tws_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [CW-1:0]               cnt;
      logic                        valid;
      logic                        full;
   } fifo_state_t;

   fifo_state_t r;
   fifo_state_t next_r;
   logic        push;
   logic        pop;

   // pointers wrap naturally, so depth must be a power of two
   always_comb begin
      next_r = r;
      push   = in_valid & ~r.full;
      pop    = r.valid & out_ready;
      if (push) begin
         next_r.mem[r.wp] = in_data;
         next_r.wp        = AW'(r.wp + 1'b1);
      end
      if (pop) begin
         next_r.rp = AW'(r.rp + 1'b1);
      end
      if (push && !pop) begin
         next_r.cnt = CW'(r.cnt + 1'b1);
      end else if (pop && !push) begin
         next_r.cnt = CW'(r.cnt - 1'b1);
      end
      next_r.valid = (next_r.cnt != '0);
      next_r.full  = (next_r.cnt == CW'(DEPTH));
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign in_ready  = ~r.full;
   assign out_valid = r.valid;
   assign out_data  = r.mem[r.rp];
endmodule

/* File: logic/tws_slave.sv */
// tuner two-wire slave port: framing, address match, pointer, byte strobes
// Operation
// - works with master clock up to 400kHz
// - master starts transfers and makes clock
// - one bit per clock, nine clocks per byte
// - data change while clock high is control
// - both lines rest high when idle
// - start: data falls while clock high
// - stop: data rises while clock high
// - receiver acks low through ninth clock
// - not-ack leaves data released high
// - master retries after a not-ack (tws_master only reports it on resp_ack, and the bench does not retry)
// - address byte: seven bits plus direction
// - address chosen by three-state select pin (tws_slave takes two select bits and adds 0 to 3 to the base)
// - watch bus for start plus own address
// - ack match, then receive or transmit
// - write: pointer byte, then data bytes
// - read: pointer write, repeated start, bytes out
`timescale 1ns/10ps
`include "tws_defines.svh"
module tws_slave (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       select_bit_hi,
   input  wire logic       select_bit_lo,
   tws_link_if.slave       link,
   output logic      [7:0] reg_ptr,
   output logic            rd_req,
   output logic      [7:0] rd_addr,
   input  wire logic [7:0] rd_data,
   output logic            wr_valid,
   input  wire logic       wr_ready,
   output logic      [7:0] wr_addr,
   output logic      [7:0] wr_data
);
   typedef struct packed {
      logic                  scl_p;
      logic                  scl_s;
      logic                  scl_d;
      logic                  sda_p;
      logic                  sda_s;
      logic                  sda_d;
      logic [1:0]            sel_p;
      logic [1:0]            sel_s;
      tws_pkg::slave_state_t st;
      logic [3:0]            cnt;
      logic [7:0]            sh;
      logic                  rw;
      logic                  first;
      logic [7:0]            ptr;
      logic                  sda_oe;
      logic                  rd_req;
      logic [7:0]            rd_addr;
      logic                  rd_get;
      logic                  push;
      logic [15:0]           push_word;
   } slave_state_regs_t;

   slave_state_regs_t r;
   slave_state_regs_t next_r;
   logic              fifo_ready;
   logic              rise;
   logic              fall;
   logic              start;
   logic              stop;
   logic [6:0]        own_addr;

   // pins pass two flops; the third copy only serves edge finding
   always_comb begin
      rise     = r.scl_s & ~r.scl_d;
      fall     = ~r.scl_s & r.scl_d;
      start    = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
      stop     = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
      own_addr = 7'(`TWS_DEV_BASE + {5'h00, r.sel_s});
   end

   // byte engine, paced only by edges of the master's clock
   always_comb begin
      next_r        = r;
      next_r.scl_p  = link.scl;
      next_r.scl_s  = r.scl_p;
      next_r.scl_d  = r.scl_s;
      next_r.sda_p  = link.sda;
      next_r.sda_s  = r.sda_p;
      next_r.sda_d  = r.sda_s;
      next_r.sel_p  = {select_bit_hi, select_bit_lo};
      next_r.sel_s  = r.sel_p;
      next_r.rd_req = 1'b0;
      next_r.push   = 1'b0;
      next_r.rd_get = r.rd_req;
      // byte from the register side arrives the cycle after the request
      if (r.rd_get) begin
         next_r.sh = rd_data;
      end
      case (r.st)
         tws_pkg::S_IDLE: begin
            next_r.cnt = 4'h0;
         end
         tws_pkg::S_ADDR: begin
            if (rise) begin
               next_r.sh  = {r.sh[6:0], r.sda_s};
               next_r.cnt = 4'(r.cnt + 1'b1);
            end
            if (fall && r.cnt == `TWS_BYTE_BITS) begin
               next_r.cnt = 4'h0;
               if (r.sh[7:1] == own_addr) begin
                  next_r.sda_oe = 1'b1;
                  next_r.rw     = r.sh[0];
                  next_r.first  = 1'b1;
                  next_r.st     = tws_pkg::S_ADDR_ACK;
                  if (r.sh[0]) begin
                     next_r.rd_req  = 1'b1;
                     next_r.rd_addr = r.ptr;
                     next_r.ptr     = 8'(r.ptr + 1'b1);
                  end
               end else begin
                  next_r.st = tws_pkg::S_IGNORE;
               end
            end
         end
         tws_pkg::S_ADDR_ACK: begin
            // ack held one full clock; on its falling edge a write releases data, a read drives its first bit
            if (fall) begin
               if (r.rw) begin
                  next_r.sda_oe = ~r.sh[7];
                  next_r.st     = tws_pkg::S_RDATA;
               end else begin
                  next_r.sda_oe = 1'b0;
                  next_r.st     = tws_pkg::S_WDATA;
               end
            end
         end
         tws_pkg::S_WDATA: begin
            if (rise) begin
               next_r.sh  = {r.sh[6:0], r.sda_s};
               next_r.cnt = 4'(r.cnt + 1'b1);
            end
            if (fall && r.cnt == `TWS_BYTE_BITS) begin
               next_r.cnt = 4'h0;
               if (r.first) begin
                  next_r.ptr    = r.sh;
                  next_r.first  = 1'b0;
                  next_r.sda_oe = 1'b1;
                  next_r.st     = tws_pkg::S_WACK;
               end else if (fifo_ready) begin
                  next_r.push      = 1'b1;
                  next_r.push_word = {r.ptr, r.sh};
                  next_r.ptr       = 8'(r.ptr + 1'b1);
                  next_r.sda_oe    = 1'b1;
                  next_r.st        = tws_pkg::S_WACK;
               end else begin
                  // buffer full: refuse the byte, master must retry
                  next_r.st = tws_pkg::S_IGNORE;
               end
            end
         end
         tws_pkg::S_WACK: begin
            if (fall) begin
               next_r.sda_oe = 1'b0;
               next_r.st     = tws_pkg::S_WDATA;
            end
         end
         tws_pkg::S_RDATA: begin
            if (rise) begin
               next_r.cnt = 4'(r.cnt + 1'b1);
            end
            if (fall) begin
               if (r.cnt == `TWS_BYTE_BITS) begin
                  next_r.cnt    = 4'h0;
                  next_r.sda_oe = 1'b0;
                  next_r.st     = tws_pkg::S_RACK;
               end else begin
                  next_r.sh     = {r.sh[6:0], 1'b0};
                  next_r.sda_oe = ~r.sh[6];
               end
            end
         end
         tws_pkg::S_RACK: begin
            // master's ack fetches the next register, not-ack ends reading
            if (rise) begin
               if (!r.sda_s) begin
                  next_r.rd_req  = 1'b1;
                  next_r.rd_addr = r.ptr;
                  next_r.ptr     = 8'(r.ptr + 1'b1);
                  next_r.st      = tws_pkg::S_ADDR_ACK;
               end else begin
                  next_r.st = tws_pkg::S_IGNORE;
               end
            end
         end
         tws_pkg::S_IGNORE: begin
            next_r.sda_oe = 1'b0;
         end
         default: begin
            next_r.st     = tws_pkg::S_IDLE;
            next_r.sda_oe = 1'b0;
         end
      endcase
      // bus conditions override every state; the slave never starts one
      if (start) begin
         next_r.st     = tws_pkg::S_ADDR;
         next_r.cnt    = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop) begin
         next_r.st     = tws_pkg::S_IDLE;
         next_r.cnt    = 4'h0;
         next_r.sda_oe = 1'b0;
      end
   end

   // sampling at 200 MHz leaves hundreds of samples per 400kHz bit
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         r       <= '0;
         r.scl_p <= 1'b1;
         r.scl_s <= 1'b1;
         r.scl_d <= 1'b1;
         r.sda_p <= 1'b1;
         r.sda_s <= 1'b1;
         r.sda_d <= 1'b1;
         r.st    <= tws_pkg::S_IDLE;
      end else begin
         r <= next_r;
      end
   end

   tws_fifo #(
      .WIDTH (`TWS_FIFO_WIDTH),
      .DEPTH (`TWS_FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_valid  (r.push),
      .in_ready  (fifo_ready),
      .in_data   (r.push_word),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  ({wr_addr, wr_data})
   );

   assign link.s_sda_out = 1'b0; // open drain: only ever pulls low
   assign link.s_sda_oe  = r.sda_oe;
   assign reg_ptr        = r.ptr;
   assign rd_req         = r.rd_req;
   assign rd_addr        = r.rd_addr;
endmodule

/* File: logic/tws_master.sv */
// two-wire bus master: makes the clock and runs start, stop and byte commands
`timescale 1ns/10ps
`include "tws_defines.svh"
module tws_master (
   input  wire logic            core_clk,
   input  wire logic            reset_n,
   tws_link_if.master           link,
   input  wire logic            cmd_valid,
   output logic                 cmd_ready,
   input  wire tws_pkg::master_op_t cmd_op,
   input  wire logic      [7:0] cmd_data,
   input  wire logic            cmd_ack,
   output logic                 resp_valid,
   output logic           [7:0] resp_data,
   output logic                 resp_ack
);
   typedef struct packed {
      logic                   sda_p;
      logic                   sda_s;
      tws_pkg::master_state_t st;
      tws_pkg::master_op_t    op;
      logic [1:0]             step;
      logic [7:0]             timer;
      logic [3:0]             cnt;
      logic [7:0]             sh;
      logic                   ackf;
      logic                   scl_oe;
      logic                   sda_oe;
      logic                   cmd_ready;
      logic                   resp_valid;
      logic [7:0]             resp_data;
      logic                   resp_ack;
   } master_state_regs_t;

   master_state_regs_t r;
   master_state_regs_t next_r;
   logic               tick;
   logic               last_bit;

   // half period of 1250 ns keeps the clock at 400kHz at most
   always_comb begin
      tick     = (r.timer == `TWS_TIMER_LAST);
      last_bit = (r.cnt == `TWS_BYTE_BITS);
   end

   always_comb begin
      next_r            = r;
      next_r.sda_p      = link.sda;
      next_r.sda_s      = r.sda_p;
      next_r.resp_valid = 1'b0;
      next_r.timer      = tick ? 8'h00 : 8'(r.timer + 1'b1);
      case (r.st)
         tws_pkg::M_IDLE: begin
            next_r.timer = 8'h00;
            if (cmd_valid) begin
               next_r.op   = cmd_op;
               next_r.sh   = cmd_data;
               next_r.ackf = cmd_ack;
               next_r.step = 2'h0;
               next_r.cnt  = 4'h0;
               if (cmd_op == tws_pkg::OP_START) begin
                  next_r.st = tws_pkg::M_START;
               end else if (cmd_op == tws_pkg::OP_STOP) begin
                  next_r.st = tws_pkg::M_STOP;
               end else begin
                  next_r.st = tws_pkg::M_BIT_LO;
               end
            end
         end
         tws_pkg::M_START: begin
            // release data, release clock, pull data, pull clock
            if (tick) begin
               next_r.step = 2'(r.step + 1'b1);
               case (r.step)
                  2'h0: next_r.sda_oe = 1'b0;
                  2'h1: next_r.scl_oe = 1'b0;
                  2'h2: next_r.sda_oe = 1'b1;
                  default: begin
                     next_r.scl_oe     = 1'b1;
                     next_r.resp_valid = 1'b1;
                     next_r.st         = tws_pkg::M_IDLE;
                  end
               endcase
            end
         end
         tws_pkg::M_STOP: begin
            if (tick) begin
               next_r.step = 2'(r.step + 1'b1);
               case (r.step)
                  2'h0: next_r.sda_oe = 1'b1;
                  2'h1: next_r.scl_oe = 1'b0;
                  default: begin
                     next_r.sda_oe     = 1'b0;
                     next_r.resp_valid = 1'b1;
                     next_r.st         = tws_pkg::M_IDLE;
                  end
               endcase
            end
         end
         tws_pkg::M_BIT_LO: begin
            // data only changes while the clock is held low
            if (r.op == tws_pkg::OP_WRITE) begin
               next_r.sda_oe = last_bit ? 1'b0 : ~r.sh[7];
            end else begin
               next_r.sda_oe = last_bit ? r.ackf : 1'b0;
            end
            if (tick) begin
               next_r.scl_oe = 1'b0;
               next_r.st     = tws_pkg::M_BIT_HI;
            end
         end
         tws_pkg::M_BIT_HI: begin
            // sample at the end of the high half, then pull clock low
            if (tick) begin
               next_r.scl_oe = 1'b1;
               if (last_bit) begin
                  next_r.resp_valid = 1'b1;
                  next_r.resp_data  = r.sh;
                  next_r.resp_ack   = (r.op == tws_pkg::OP_WRITE) ? ~r.sda_s : r.ackf;
                  next_r.st         = tws_pkg::M_IDLE;
               end else begin
                  if (r.op == tws_pkg::OP_WRITE) begin
                     next_r.sh = {r.sh[6:0], 1'b0};
                  end else begin
                     next_r.sh = {r.sh[6:0], r.sda_s};
                  end
                  next_r.cnt = 4'(r.cnt + 1'b1);
                  next_r.st  = tws_pkg::M_BIT_LO;
               end
            end
         end
         default: begin
            next_r.st = tws_pkg::M_IDLE;
         end
      endcase
      next_r.cmd_ready = (next_r.st == tws_pkg::M_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         r           <= '0;
         r.sda_p     <= 1'b1;
         r.sda_s     <= 1'b1;
         r.st        <= tws_pkg::M_IDLE;
         r.op        <= tws_pkg::OP_START;
         r.cmd_ready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign link.m_scl_out = 1'b0;
   assign link.m_scl_oe  = r.scl_oe;
   assign link.m_sda_out = 1'b0;
   assign link.m_sda_oe  = r.sda_oe;
   assign cmd_ready      = r.cmd_ready;
   assign resp_valid     = r.resp_valid;
   assign resp_data      = r.resp_data;
   assign resp_ack       = r.resp_ack;
endmodule

/* File: tb/tws_link_monitor.sv */
// link checker: framing, start/stop and drive timing on the two wires
`timescale 1ns/10ps
module tws_link_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic m_scl_oe,
   input wire logic m_sda_oe,
   input wire logic s_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_q;
   logic       sda_q;
   logic       first;
   logic [3:0] rises;
   logic [9:0] held;

   // clock rises since start, and how long the slave has pulled data low
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         first <= 1'b0;
         rises <= 4'h0;
         held  <= 10'h000;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         held  <= s_sda_oe ? held + {9'h000, ~&held} : 10'h000;
         if (scl && scl_q && sda_q && !sda) begin
            first <= 1'b1;
            rises <= 4'h0;
         end else if (scl && !scl_q) begin
            rises <= (rises == 4'h9) ? 4'h1 : rises + 4'h1;
            if (rises == 4'h9) first <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_start;
      scl && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $rose(sda);
   endsequence

   property p_released_after_reset;
      $rose(reset_n) |-> (!m_scl_oe && !m_sda_oe && !s_sda_oe)[*4];
   endproperty
   property p_slave_moves_scl_low;
      $changed(s_sda_oe) |-> !scl && !$past(scl);
   endproperty
   property p_scl_min_high;
      $rose(scl) |-> scl[*8];
   endproperty
   property p_scl_min_low;
      $fell(scl) |-> !scl[*8];
   endproperty
   property p_addr_quiet;
      first && rises < 4'h8 |-> !s_sda_oe;
   endproperty
   property p_ack_full_period;
      $fell(s_sda_oe) |-> held >= 10'h190;
   endproperty
   property p_stop_idle;
      s_stop |-> (scl && sda && !s_sda_oe)[*8];
   endproperty
   property p_start_frame;
      s_start |-> scl[*8] ##[1:1000] !scl;
   endproperty

   a_released_after_reset: assert property (p_released_after_reset)
      else $error("bus not released after reset");
   a_slave_moves_scl_low: assert property (p_slave_moves_scl_low)
      else $error("slave moved data while clock high");
   a_scl_min_high: assert property (p_scl_min_high)
      else $error("clock high too short");
   a_scl_min_low: assert property (p_scl_min_low)
      else $error("clock low too short");
   a_addr_quiet: assert property (p_addr_quiet)
      else $error("slave drove during address bits");
   a_ack_full_period: assert property (p_ack_full_period)
      else $error("slave drive shorter than a clock period");
   a_stop_idle: assert property (p_stop_idle)
      else $error("lines not idle after stop");
   a_start_frame: assert property (p_start_frame)
      else $error("start not followed by clock");
endmodule

/* File: tb/tb_top.sv */
// bench: master and tuner port face each other, bench plays the register file
`timescale 1ns/10ps
module tb_top;
   logic                core_clk = 1'b0;
   logic                reset_n = 1'b0;
   logic                sel_hi = 1'b0;
   logic                sel_lo = 1'b0;
   logic                cmd_valid = 1'b0;
   tws_pkg::master_op_t cmd_op = tws_pkg::OP_STOP;
   logic [7:0]          cmd_data = 8'h00;
   logic                cmd_ack = 1'b0;
   logic                cmd_ready, resp_valid, resp_ack, rd_req, wr_valid;
   logic [7:0]          resp_data, reg_ptr, rd_addr, wr_addr, wr_data;
   logic [7:0]          rd_data = 8'h00;
   logic                wr_ready = 1'b0;
   logic                stall = 1'b0;
   logic [7:0]          own = 8'hc0;
   logic [31:0]         rng = 32'h00017ad9;
   logic [7:0]          dev_mem [256];
   int                  exp_mem [256];
   logic [15:0]         exp_q [$];
   int                  num_errors = 0;
   int                  cmp_count = 0;

   tws_link_if link ();

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   tws_master tws_master_inst (.core_clk(core_clk), .reset_n(reset_n), .link(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
      .cmd_ack(cmd_ack), .resp_valid(resp_valid), .resp_data(resp_data), .resp_ack(resp_ack));
   tws_slave tws_slave_inst (.core_clk(core_clk), .reset_n(reset_n), .select_bit_hi(sel_hi),
      .select_bit_lo(sel_lo), .link(link), .reg_ptr(reg_ptr), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_data(wr_data));
   tws_link_monitor tws_link_monitor_inst (.core_clk(core_clk), .reset_n(reset_n),
      .m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe),
      .scl(link.scl), .sda(link.sda));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic final_report;
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one master command, held until taken, then bounded wait for its answer
   task automatic cmd(input tws_pkg::master_op_t op, input logic [7:0] d, input logic a);
      int i;
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      cmd_ack <= a;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (cmd_ready !== 1'b1 && i < 20);
      cmd_valid <= 1'b0;
      do begin
         @(posedge core_clk);
         i++;
      end while (resp_valid !== 1'b1 && i < 6000);
      if (i >= 6000) begin
         num_errors++;
         $display("Error at %0t: no answer from master", $time);
         final_report();
      end
   endtask

   // write: address, pointer, n bytes of which the first take fit the fifo
   task automatic burst(input logic [7:0] ptr, input int n, input int take);
      logic [7:0] d;
      cmd(tws_pkg::OP_START, 8'h00, 1'b0);
      cmd(tws_pkg::OP_WRITE, own, 1'b0);
      check(16'(resp_ack), 16'h0001, "address ack");
      cmd(tws_pkg::OP_WRITE, ptr, 1'b0);
      check(16'(resp_ack), 16'h0001, "pointer ack");
      for (int k = 0; k < n; k++) begin
         d = rng[15:8];
         // queued before sending: the port may pop the word before the ack bit ends
         if (k < take) begin
            exp_q.push_back({ptr + 8'(k), d});
            exp_mem[ptr + 8'(k)] = d;
         end
         cmd(tws_pkg::OP_WRITE, d, 1'b0);
         check(16'(resp_ack), 16'(k < take), "data ack");
      end
      cmd(tws_pkg::OP_STOP, 8'h00, 1'b0);
      // pointer is eight bits wide and wraps past ff
      check(16'(reg_ptr), 16'(8'(ptr + 8'(take))), "pointer after write");
   endtask

   task automatic drain;
      for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge core_clk);
      if (exp_q.size() > 0) begin
         num_errors++;
         $display("Error at %0t: fifo words missing", $time);
         final_report();
      end
   endtask

   // register file side: random pop stalls, read data the cycle after request
   always @(posedge core_clk) begin
      rng <= xs(rng);
      wr_ready <= !stall && rng[0];
      if (rd_req === 1'b1) rd_data <= dev_mem[rd_addr];
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
         dev_mem[wr_addr] <= wr_data;
         if (exp_q.size() > 0) begin
            check({wr_addr, wr_data}, exp_q.pop_front(), "fifo word");
         end else begin
            num_errors++;
            $display("Error at %0t: unexpected fifo word", $time);
         end
      end
   end

   initial begin
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      // another device's address is left unanswered
      cmd(tws_pkg::OP_START, 8'h00, 1'b0);
      cmd(tws_pkg::OP_WRITE, 8'hc2, 1'b0);
      check(16'(resp_ack), 16'h0000, "foreign ack");
      cmd(tws_pkg::OP_STOP, 8'h00, 1'b0);
      // strap settings 0 to 2 each answer their own write address
      for (int s = 0; s < 3; s++) begin
         {sel_hi, sel_lo} <= 2'(s);
         own <= 8'hc0 | {5'h00, 2'(s), 1'b0};
         repeat (4) @(posedge core_clk);
         cmd(tws_pkg::OP_START, 8'h00, 1'b0);
         cmd(tws_pkg::OP_WRITE, own, 1'b0);
         check(16'(resp_ack), 16'h0001, "strap address ack");
         cmd(tws_pkg::OP_STOP, 8'h00, 1'b0);
      end
      // fifo held full: fifth byte refused, pointer wraps past ff
      stall <= 1'b1;
      burst(8'hfe, 5, 4);
      stall <= 1'b0;
      drain();
      burst(8'h02, 1, 1);
      drain();
      // pointer write, repeated start, read two bytes, nack ends
      cmd(tws_pkg::OP_START, 8'h00, 1'b0);
      cmd(tws_pkg::OP_WRITE, own, 1'b0);
      cmd(tws_pkg::OP_WRITE, 8'hfe, 1'b0);
      cmd(tws_pkg::OP_START, 8'h00, 1'b0);
      cmd(tws_pkg::OP_WRITE, own | 8'h01, 1'b0);
      check(16'(resp_ack), 16'h0001, "read address ack");
      for (int k = 0; k < 2; k++) begin
         cmd(tws_pkg::OP_READ, 8'h00, k == 0);
         check(16'(resp_data), 16'(exp_mem[8'hfe + 8'(k)]), "read byte");
      end
      cmd(tws_pkg::OP_STOP, 8'h00, 1'b0);
      repeat (10) @(posedge core_clk);
      final_report();
   end
endmodule
